/* verilog/smh_servo_motion_handshake.sv */
// Top of the servo motion handshake: start qualification, flags, torque limit and alarm handling.
`timescale 1ns/1ns
`default_nettype none
module smh_servo_motion_handshake
   import smh_pkg::*;
#(
   parameter int UV_CYCLES = UV_LOSS_CYC
)
(
   input wire logic clk,
   input wire logic srst,
   input wire smh_cmd_t cmd,
   input wire logic mainPowerOk,
   input wire logic controlPowerLost,
   input wire logic forcedStopInput,
   input wire logic alarmCause,
   input wire logic panelSetButton,
   input wire logic incrementalMode,
   input wire logic [POS_W-1:0] remainingCommand,
   input wire logic [POS_W-1:0] droopPulses,
   input wire logic commandDone,
   input wire logic [POS_W-1:0] inPositionRange,
   input wire logic [POS_W-1:0] roughMatchRange,
   input wire logic [TQ_W-1:0] torqueLimit1,
   input wire logic [TQ_W-1:0] torqueLimit2,
   input wire logic torqueAtLimit,
   input wire logic homeDone,
   output smh_status_t status,
   output logic startFwd,
   output logic startRev,
   output logic moveActive,
   output logic powerStageOn,
   output logic undervoltageAlarm,
   output logic homeValid,
   output logic [TQ_W-1:0] torqueLimit
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Unsigned compare, so a range of zero asks for an exact match.
   function automatic logic withinRange(input logic [POS_W-1:0] value, input logic [POS_W-1:0] bound);
      withinRange = (value <= bound);
   endfunction : withinRange

   // ----------------------------------------
   // Command synchronisation
   // ----------------------------------------
   localparam int NCMD = 7;
   // Start, reset and select bits pass the same two stages, so their relative order is kept.
   logic [NCMD-1:0] cmdLevel;
   logic [NCMD-1:0] cmdRise;
   logic [TQ_W-1:0] torqueSel;

   smh_edge_sync #(.W(NCMD)) u_sync
   (
      .clk(clk),
      .srst(srst),
      .din(cmd),
      .level(cmdLevel),
      .rise(cmdRise)
   );

   smh_cmd_t lvl, rse;
   assign lvl = smh_cmd_t'(cmdLevel);
   assign rse = smh_cmd_t'(cmdRise);

   smh_torque_select u_tq
   (
      .limit1(torqueLimit1),
      .limit2(torqueLimit2),
      .select(lvl.torqueLimitSelect),
      .limit(torqueSel)
   );

   // ----------------------------------------
   // Alarm and undervoltage
   // ----------------------------------------
   logic alarm_reg, alarm_next;
   logic uv_reg, uv_next;
   logic [CNT_W-1:0] lossCnt_reg, lossCnt_next;
   logic home_reg, home_next;
   logic resetReq;

   always_comb
   begin
      resetReq = rse.alarmResetA | rse.alarmResetB | panelSetButton;
      lossCnt_next = lossCnt_reg;
      uv_next = uv_reg;
      // The count stops one short of the limit, so the alarm holds for as long as the loss lasts.
      if (!controlPowerLost)
      begin
         lossCnt_next = '0;
      end
      else if (lossCnt_reg < CNT_W'(UV_CYCLES - 1))
      begin
         lossCnt_next = lossCnt_reg + CNT_W'(1);
      end
      else
      begin
         uv_next = 1'b1;
      end
      // A reset during the loss is ignored, so the alarm cannot hide a supply that is still down.
      if (resetReq && !controlPowerLost)
      begin
         uv_next = 1'b0;
      end
      alarm_next = alarm_reg;
      // A live cause wins over the reset so the alarm cannot be cleared while it persists.
      if (alarmCause || uv_next)
      begin
         alarm_next = 1'b1;
      end
      else if (resetReq)
      begin
         alarm_next = 1'b0;
      end
      // Absolute mode keeps its home across an alarm; only incremental mode must search again.
      home_next = home_reg;
      if (homeDone)
      begin
         home_next = 1'b1;
      end
      if (alarm_next && incrementalMode)
      begin
         home_next = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         alarm_reg <= 1'b0;
         uv_reg <= 1'b0;
         lossCnt_reg <= '0;
         home_reg <= 1'b0;
      end
      else
      begin
         alarm_reg <= alarm_next;
         uv_reg <= uv_next;
         lossCnt_reg <= lossCnt_next;
         home_reg <= home_next;
      end
   end

   // ----------------------------------------
   // Start qualification and move tracking
   // ----------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_MOVE, ST_STOPPED} smh_state_t;
   smh_state_t state_reg, state_next;
   logic fwd_reg, fwd_next;
   logic rev_reg, rev_next;
   // Registered beside the state so the move flag leaves the block straight from a flip-flop.
   logic move_reg, move_next;
   logic driveOk;

   always_comb
   begin
      driveOk = lvl.servoOn && !alarm_next && !forcedStopInput;
      state_next = state_reg;
      fwd_next = 1'b0;
      rev_next = 1'b0;
      unique case (state_reg)
         ST_IDLE:
         begin
            // Edges are honoured only with main power up; held levels never retrigger.
            // Forward wins when both edges land in the same cycle.
            if (driveOk && mainPowerOk && (rse.fwdStart || rse.revStart))
            begin
               fwd_next = rse.fwdStart;
               rev_next = rse.revStart && !rse.fwdStart;
               state_next = ST_MOVE;
            end
         end
         ST_MOVE:
         begin
            // Start edges here are dropped, not queued.
            if (!driveOk)
            begin
               state_next = ST_STOPPED;
            end
            else if (commandDone)
            begin
               state_next = ST_IDLE;
            end
         end
         ST_STOPPED:
         begin
            // The stop is left once drive is allowed again; the position flags step high then.
            if (driveOk)
            begin
               state_next = ST_IDLE;
            end
         end
      endcase
      move_next = (state_next == ST_MOVE);
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_reg <= ST_IDLE;
         move_reg <= 1'b0;
         fwd_reg <= 1'b0;
         rev_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         move_reg <= move_next;
         fwd_reg <= fwd_next;
         rev_reg <= rev_next;
      end
   end

   // ----------------------------------------
   // Status flags
   // ----------------------------------------
   smh_status_t st_reg, st_next;
   logic stage_reg, stage_next;
   logic [TQ_W-1:0] tq_reg, tq_next;

   always_comb
   begin
      // Ready follows this cycle's alarm, so ready never stands beside a fresh alarm.
      st_next.readyFlag = lvl.servoOn && mainPowerOk && !alarm_next;
      st_next.alarmFlag = alarm_next;
      // Limiting is gated by last cycle's power stage, so the flag trails powerStageOn by one cycle.
      st_next.torqueLimitingFlag = torqueAtLimit && stage_reg;
      if (!lvl.servoOn)
      begin
         st_next.moveFinishFlag = 1'b0;
         st_next.roughMatchFlag = 1'b0;
         st_next.inPositionFlag = 1'b0;
      end
      else if (state_reg == ST_STOPPED && driveOk)
      begin
         st_next.moveFinishFlag = 1'b1;
         st_next.roughMatchFlag = 1'b1;
         st_next.inPositionFlag = 1'b1;
      end
      else
      begin
         st_next.moveFinishFlag = commandDone && withinRange(remainingCommand, inPositionRange)
            && state_next != ST_MOVE;
         st_next.roughMatchFlag = withinRange(remainingCommand, roughMatchRange);
         st_next.inPositionFlag = withinRange(droopPulses, inPositionRange);
      end
      stage_next = driveOk && mainPowerOk;
      tq_next = torqueSel;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         st_reg <= '0;
         stage_reg <= 1'b0;
         tq_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
         stage_reg <= stage_next;
         tq_reg <= tq_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign status = st_reg;
   assign startFwd = fwd_reg;
   assign startRev = rev_reg;
   assign moveActive = move_reg;
   assign powerStageOn = stage_reg;
   assign undervoltageAlarm = uv_reg;
   assign homeValid = home_reg;
   assign torqueLimit = tq_reg;
endmodule : smh_servo_motion_handshake
`default_nettype wire

/* verilog/smh_pkg.sv */
// Package with constants and carrier types for the servo motion handshake block.
package smh_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int START_DELAY_MS = 5;
   localparam int OTHER_DELAY_MS = 10;
   localparam int UV_LOSS_MS = 60;
   localparam int START_DELAY_CYC = START_DELAY_MS * 1000 * CLK_MHZ;
   localparam int OTHER_DELAY_CYC = OTHER_DELAY_MS * 1000 * CLK_MHZ;
   localparam int UV_LOSS_CYC = UV_LOSS_MS * 1000 * CLK_MHZ;
   // Start edges reach the motion core this many cycles after the raw command changes.
   localparam int SYNC_STAGES = 2;
   // ----------------------------------------
   // Widths and limits
   // ----------------------------------------
   localparam int TQ_W = 7;
   localparam logic [TQ_W-1:0] TQ_MAX = 7'h64;
   localparam int POS_W = 16;
   localparam int CNT_W = 24;

   typedef struct packed {
      logic servoOn;
      logic fwdStart;
      logic revStart;
      logic startStop;
      logic torqueLimitSelect;
      logic alarmResetA;
      logic alarmResetB;
   } smh_cmd_t;

   typedef struct packed {
      logic readyFlag;
      logic roughMatchFlag;
      logic moveFinishFlag;
      logic inPositionFlag;
      logic torqueLimitingFlag;
      logic alarmFlag;
   } smh_status_t;
endpackage : smh_pkg

/* verilog/smh_edge_sync.sv */
// Two-stage synchroniser with rising-edge detection for a group of command bits.
`timescale 1ns/1ns
`default_nettype none
module smh_edge_sync
   import smh_pkg::*;
#(
   parameter int W = 7
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] level,
   output logic [W-1:0] rise
);
   logic [W-1:0] meta_reg, meta_next;
   logic [W-1:0] sync_reg, sync_next;
   logic [W-1:0] last_reg, last_next;

   always_comb
   begin
      meta_next = din;
      sync_next = meta_reg;
      last_next = sync_reg;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
         last_reg <= '0;
      end
      else
      begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
         last_reg <= last_next;
      end
   end

   assign level = sync_reg;
   assign rise = sync_reg & ~last_reg;
endmodule : smh_edge_sync
`default_nettype wire

/* verilog/smh_torque_select.sv */
// Torque limit selection: setting 1, or the lower of the two settings when select is high.
`timescale 1ns/1ns
`default_nettype none
module smh_torque_select
   import smh_pkg::*;
(
   input wire logic [TQ_W-1:0] limit1,
   input wire logic [TQ_W-1:0] limit2,
   input wire logic select,
   output logic [TQ_W-1:0] limit
);
   function automatic logic [TQ_W-1:0] clampPct(input logic [TQ_W-1:0] v);
      clampPct = (v > TQ_MAX) ? TQ_MAX : v;
   endfunction : clampPct

   logic [TQ_W-1:0] l1, l2;

   always_comb
   begin
      l1 = clampPct(limit1);
      l2 = clampPct(limit2);
      if (!select)
      begin
         limit = l1;
      end
      else
      begin
         limit = (l2 < l1) ? l2 : l1;
      end
   end
endmodule : smh_torque_select
`default_nettype wire

/* sim/smh_plc_model.sv */
// Controller model that drives the command bits of the handshake block.
`timescale 1ns/1ns
`default_nettype none
module smh_plc_model
   import smh_pkg::*;
#(
   parameter int HOLD = 12
)
(
   input wire logic clk,
   input wire smh_status_t status,
   output smh_cmd_t cmd
);
   // ----
   // Sequences
   // ----
   // HOLD stands in for the long minimum on-time so that runs stay short.
   initial cmd = '0;
   task automatic start(input logic rev, input logic gate);
      int k;
      k = 0;
      while (gate && status.readyFlag !== 1'b1 && k < 50)
      begin
         @(negedge clk);
         k++;
      end
      // Only the chosen bit moves, so a following call may raise the other bit on the same edge.
      if (rev)
         cmd.revStart = 1'b1;
      else
         cmd.fwdStart = 1'b1;
      repeat (HOLD) @(negedge clk);
      if (rev)
         cmd.revStart = 1'b0;
      else
         cmd.fwdStart = 1'b0;
   endtask : start
   task automatic alarmReset(input logic useB);
      cmd.servoOn = 1'b0;
      @(negedge clk);
      cmd.alarmResetA = !useB;
      cmd.alarmResetB = useB;
      repeat (HOLD) @(negedge clk);
      cmd.alarmResetA = 1'b0;
      cmd.alarmResetB = 1'b0;
   endtask : alarmReset
   task automatic setLevels(input logic servo, input logic sel);
      cmd.servoOn = servo;
      cmd.torqueLimitSelect = sel;
   endtask : setLevels
endmodule : smh_plc_model
`default_nettype wire

/* sim/smh_chk.sv */
// Port checker of the servo motion handshake block.
`timescale 1ns/1ns
`default_nettype none
module smh_chk
   import smh_pkg::*;
#(
   parameter int UV_CYCLES = UV_LOSS_CYC
)
(
   input wire logic clk,
   input wire logic srst,
   input wire smh_cmd_t cmd,
   input wire logic mainPowerOk,
   input wire logic controlPowerLost,
   input wire logic alarmCause,
   input wire logic incrementalMode,
   input wire logic [TQ_W-1:0] torqueLimit1,
   input wire logic [TQ_W-1:0] torqueLimit2,
   input wire smh_status_t status,
   input wire logic startFwd,
   input wire logic startRev,
   input wire logic moveActive,
   input wire logic undervoltageAlarm,
   input wire logic homeValid,
   input wire logic powerStageOn,
   input wire logic [TQ_W-1:0] torqueLimit
);
   // ----
   // Helpers
   // ----
   logic [31:0] loss_reg;
   logic [31:0] loss_next;
   logic [TQ_W-1:0] lim1;
   logic [TQ_W-1:0] lim2;
   always_comb
   begin
      loss_next = controlPowerLost ? loss_reg + 32'h1 : 32'h0;
      lim1 = torqueLimit1 > TQ_MAX ? TQ_MAX : torqueLimit1;
      lim2 = torqueLimit2 > TQ_MAX ? TQ_MAX : torqueLimit2;
   end
   always_ff @(posedge clk)
   begin
      loss_reg <= srst ? 32'h0 : loss_next;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // ----
   // Properties
   // ----
   a_start_idle: assert property (startFwd | startRev |-> moveActive && !$past(moveActive))
      else $error("start pulse during a move");
   a_start_power: assert property (startFwd | startRev |-> $past(mainPowerOk))
      else $error("start pulse without main power");
   a_start_pulse: assert property (startFwd |=> !startFwd)
      else $error("start pulse longer than one cycle");
   a_alarm_cut: assert property (alarmCause |=> !powerStageOn && status.alarmFlag)
      else $error("power stage left on after alarm");
   a_alarm_keep: assert property ($fell(status.alarmFlag) |-> !$past(alarmCause))
      else $error("alarm cleared while cause present");
   a_flags_servo: assert property ((!cmd.servoOn)[*4] |-> !(status.moveFinishFlag
      || status.roughMatchFlag || status.inPositionFlag))
      else $error("position flag without servo on");
   a_tq_low: assert property ($stable({cmd, torqueLimit1, torqueLimit2})[*5] ##0 !cmd.torqueLimitSelect
      |-> torqueLimit == lim1)
      else $error("wrong torque limit with select low");
   a_tq_min: assert property ($stable({cmd, torqueLimit1, torqueLimit2})[*5] ##0 cmd.torqueLimitSelect
      |-> torqueLimit == (lim2 < lim1 ? lim2 : lim1))
      else $error("wrong torque limit with select high");
   a_uv_time: assert property ($rose(undervoltageAlarm) |-> loss_reg >= UV_CYCLES)
      else $error("undervoltage raised too early");
   a_home_drop: assert property ($rose(status.alarmFlag) && incrementalMode |-> ##[0:1] !homeValid)
      else $error("home kept after alarm");
   c_fwd: cover property (startFwd);
   c_rev: cover property (startRev);
   c_clear: cover property ($fell(status.alarmFlag));
endmodule : smh_chk
bind smh_servo_motion_handshake smh_chk #(.UV_CYCLES(UV_CYCLES)) i_chk (.clk, .srst, .cmd, .mainPowerOk,
   .controlPowerLost, .alarmCause, .incrementalMode, .torqueLimit1, .torqueLimit2, .status, .startFwd,
   .startRev, .moveActive, .undervoltageAlarm, .homeValid, .powerStageOn, .torqueLimit);
`default_nettype wire

/* sim/testbench.sv */
// Self-checking testbench of the servo motion handshake block.
`timescale 1ns/1ns
`default_nettype none
module testbench
   import smh_pkg::*;
;
   logic clk = 1'b0;
   logic srst = 1'b1;
   smh_cmd_t cmd;
   smh_status_t status;
   logic mainPowerOk = 1'b0, controlPowerLost = 1'b0, forcedStopInput = 1'b0, alarmCause = 1'b0;
   logic panelSetButton = 1'b0, incrementalMode = 1'b1, commandDone = 1'b0, torqueAtLimit = 1'b0;
   logic homeDone = 1'b0;
   logic [POS_W-1:0] remainingCommand = 16'h0, droopPulses = 16'h2, inPositionRange = 16'h4;
   logic [POS_W-1:0] roughMatchRange = 16'h8;
   logic [TQ_W-1:0] torqueLimit1 = 7'h1e, torqueLimit2 = 7'h46, torqueLimit;
   logic startFwd, startRev, moveActive, powerStageOn, undervoltageAlarm, homeValid;
   int failCount = 0, numChecks = 0, cycles = 0, nFwd = 0, nRev = 0;
   always #5 clk = ~clk;
   smh_servo_motion_handshake #(.UV_CYCLES(20)) i_dut (.clk, .srst, .cmd, .mainPowerOk, .controlPowerLost,
      .forcedStopInput, .alarmCause, .panelSetButton, .incrementalMode, .remainingCommand, .droopPulses,
      .commandDone, .inPositionRange, .roughMatchRange, .torqueLimit1, .torqueLimit2, .torqueAtLimit,
      .homeDone, .status, .startFwd, .startRev, .moveActive, .powerStageOn, .undervoltageAlarm, .homeValid,
      .torqueLimit);
   smh_plc_model #(.HOLD(12)) i_plc (.clk, .status, .cmd);
   // ----
   // Helpers
   // ----
   task automatic giveVerdict();
      if (failCount == 0 && numChecks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : giveVerdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp)
      begin
         $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
         failCount++;
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   // Start pulses last one cycle, so they are counted as they occur.
   always @(posedge clk)
   begin
      cycles++;
      nFwd += (startFwd === 1'b1);
      nRev += (startRev === 1'b1);
      if (cycles == 5000)
      begin
         failCount++;
         giveVerdict();
      end
   end
   // ----
   // Scenarios
   // ----
   task automatic tStart();
      int f;
      int r;
      f = nFwd;
      r = nRev;
      i_plc.setLevels(1'b1, 1'b0);
      i_plc.start(1'b0, 1'b0);
      chk(nFwd - f, 0);
      mainPowerOk = 1'b1;
      i_plc.start(1'b0, 1'b1);
      chk({nFwd - f, moveActive}, 3);
      i_plc.start(1'b1, 1'b0);
      chk(nRev - r, 0);
      commandDone = 1'b1;
      cyc(3);
      chk(moveActive, 0);
      chk(status.moveFinishFlag, 1);
      i_plc.start(1'b1, 1'b1);
      chk(nRev - r, 1);
   endtask : tStart
   task automatic tFlags();
      cyc(8);
      chk({status.moveFinishFlag, status.roughMatchFlag, status.inPositionFlag}, 7);
      commandDone = 1'b0;
      i_plc.start(1'b0, 1'b1);
      forcedStopInput = 1'b1;
      cyc(2);
      chk({moveActive, powerStageOn}, 0);
      forcedStopInput = 1'b0;
      cyc(1);
      chk({status.moveFinishFlag, status.roughMatchFlag, status.inPositionFlag}, 7);
      commandDone = 1'b1;
      droopPulses = 16'h9;
      remainingCommand = 16'h6;
      cyc(8);
      chk({status.moveFinishFlag, status.roughMatchFlag, status.inPositionFlag}, 2);
      droopPulses = 16'h2;
      i_plc.setLevels(1'b0, 1'b0);
      cyc(8);
      chk(status.roughMatchFlag, 0);
      chk(status.inPositionFlag, 0);
   endtask : tFlags
   task automatic tTorque();
      logic [21:0] t[6];
      t = '{{1'b0, 7'h14, 7'h05, 7'h14}, {1'b1, 7'h14, 7'h05, 7'h05}, {1'b1, 7'h1e, 7'h46, 7'h1e},
         {1'b0, 7'h78, 7'h32, 7'h64}, {1'b1, 7'h78, 7'h6e, 7'h64}, {1'b1, 7'h64, 7'h00, 7'h00}};
      foreach (t[i])
      begin
         i_plc.setLevels(1'b1, t[i][21]);
         torqueLimit1 = t[i][20:14];
         torqueLimit2 = t[i][13:7];
         cyc(6);
         chk(torqueLimit, t[i][6:0]);
      end
      torqueAtLimit = 1'b1;
      cyc(2);
      chk({status.torqueLimitingFlag, status.readyFlag}, 3);
   endtask : tTorque
   task automatic tAlarm();
      homeDone = 1'b1;
      cyc(1);
      homeDone = 1'b0;
      alarmCause = 1'b1;
      cyc(3);
      chk({powerStageOn, status.alarmFlag, homeValid}, 2);
      chk({status.torqueLimitingFlag, status.readyFlag}, 0);
      i_plc.alarmReset(1'b0);
      chk(status.alarmFlag, 1);
      alarmCause = 1'b0;
      i_plc.alarmReset(1'b1);
      cyc(4);
      chk(status.alarmFlag, 0);
      alarmCause = 1'b1;
      cyc(1);
      alarmCause = 1'b0;
      cyc(2);
      chk(status.alarmFlag, 1);
      panelSetButton = 1'b1;
      cyc(1);
      panelSetButton = 1'b0;
      cyc(2);
      chk(status.alarmFlag, 0);
   endtask : tAlarm
   task automatic tUv();
      incrementalMode = 1'b0;
      homeDone = 1'b1;
      cyc(1);
      homeDone = 1'b0;
      controlPowerLost = 1'b1;
      cyc(15);
      chk(undervoltageAlarm, 0);
      cyc(15);
      chk(undervoltageAlarm, 1);
      chk(homeValid, 1);
      controlPowerLost = 1'b0;
      i_plc.alarmReset(1'b0);
      cyc(3);
      chk(undervoltageAlarm, 0);
   endtask : tUv
   initial
   begin
      cyc(3);
      chk({status, startFwd, startRev, moveActive, powerStageOn, undervoltageAlarm, homeValid, torqueLimit}, 0);
      cyc(1);
      srst = 1'b0;
      tStart();
      tFlags();
      tTorque();
      tAlarm();
      tUv();
      giveVerdict();
   end
endmodule : testbench
`default_nettype wire
